// file: core/cntc_pkg.sv
// constants and types for the configuration memory transfer control block
package cntc_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] CNTC_OFS_BUSY = 12'hB00;
    localparam logic [11:0] CNTC_OFS_ERR = 12'hB01;
    localparam logic [11:0] CNTC_OFS_CTRL1 = 12'hB02;
    localparam logic [11:0] CNTC_OFS_CTRL2 = 12'hB03;
    localparam logic [11:0] CNTC_OFS_STAT_PIN = 12'h232;
    localparam logic [11:0] CNTC_OFS_APPLY = 12'h234;
    localparam logic [11:0] CNTC_OFS_SEG_FIRST = 12'hA00;
    localparam logic [11:0] CNTC_OFS_SEG_LAST = 12'hA16;
    localparam int CNTC_SEG_LEN = 23;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CNTC_BIT_BUSY = 0;
    localparam int CNTC_BIT_ERR = 0;
    localparam int CNTC_BIT_WREN = 0;
    localparam int CNTC_BIT_SOFT = 1;
    localparam int CNTC_BIT_STORE = 0;
    localparam int CNTC_BIT_STAT_BUSY = 4;
    localparam int CNTC_BIT_APPLY = 0;

    // ----------------------------------------------------------------
    // segment list opcodes and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CNTC_OP_END = 8'hFF;
    localparam logic [7:0] CNTC_OP_APPLY = 8'h80;
    localparam logic [7:0] CNTC_SEG_RST = 8'hFF;
    localparam logic CNTC_CTRL_RST = 1'b0;
    localparam logic CNTC_BOOT_RST = 1'b1;

    // transfer engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEG,
        ST_RD,
        ST_REQ,
        ST_WR,
        ST_CHK,
        ST_DONE
    } cntc_state_t;

endpackage

// file: core/cntc_sync.sv
// three-stage synchroniser for a pin input, output moves when stages two and three agree
`timescale 1ns/1ps
module cntc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin side
    input wire logic pin_in,
    // synchronised level
    output logic level_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    // ----------------------------------------------------------------
    // stage chain and agreement filter
    // ----------------------------------------------------------------
    // take the new level only once the last two stages agree
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            level_reg <= RST_VAL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;
endmodule

// file: core/cntc_top.sv
// configuration memory transfer control: registers, segment list and transfer engine
// Functional notes
// (R1) Bit 0 of the busy register reads 1 while a transfer runs and 0 once it is done.
// (R2) The busy flag covers both store to memory and load from memory.
// (R3) With bit 4 of the status pin register set, status_output_zero shows the busy flag.
// (R4) Bit 0 of the error register reads 1 when a load found bad data, else 0.
// (R5) With boot_select low, writing 1 to the reload bit soft-resets and reloads, then clears.
// (R6) Memory stays write-protected while the write-enable bit is 0, its reset value; the bit gates only the start of a store, not one already running.
// (R7) Writing 1 to the store bit starts a store of the buffer bank into memory.
// (R8) The store bit clears itself when the store has finished.
// (R9) The engine walks the segment list of address/count runs, apply and end opcodes.
// (R10) Writing 1 to the apply bit copies buffer to active registers, then clears.
// (R11) A store while protected is ignored, and each transfer updates the error flag.
`timescale 1ns/1ps
module cntc_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register access from the serial control port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // pins
    input wire logic boot_select,
    input wire logic status_other,
    output logic status_output_zero,
    // buffer register bank
    output logic [11:0] buf_addr,
    input wire logic [7:0] buf_rdata,
    output logic [7:0] buf_wdata,
    output logic buf_we,
    // nonvolatile memory
    output logic nvm_req,
    output logic nvm_we,
    output logic [11:0] nvm_addr,
    output logic [7:0] nvm_wdata,
    input wire logic [7:0] nvm_rdata,
    input wire logic nvm_ack,
    // effects on the rest of the chip
    output logic apply_pulse,
    output logic soft_reset
);
    import cntc_pkg::*;

    cntc_state_t state_reg, state_next;
    logic [4:0] ptr_reg, ptr_next;
    logic [6:0] cnt_reg, cnt_next;
    logic [11:0] baddr_reg, baddr_next;
    logic [11:0] naddr_reg, naddr_next;
    logic [7:0] data_reg, data_next;
    logic [7:0] sum_reg, sum_next;
    logic dir_reg, dir_next;
    logic err_reg, err_next;
    logic [7:0] seg_reg [CNTC_SEG_LEN];
    logic [7:0] seg_next [CNTC_SEG_LEN];
    logic wren_reg, wren_next;
    logic store_reg, store_next;
    logic soft_reg, soft_next;
    logic stat_en_reg, stat_en_next;
    logic apply_reg, apply_next;
    logic soft_pulse_reg;
    logic [7:0] rdata_reg, rdata_next;
    logic boot_level;
    logic busy;
    logic start_store;
    logic start_load;
    logic apply_eng;
    logic step;
    logic [7:0] entry;
    logic [7:0] entry_hi;
    logic [7:0] entry_lo;

    // segment list byte, zero beyond the end of the list
    function automatic logic [7:0] seg_at(input logic [7:0] list [CNTC_SEG_LEN],
                                          input logic [4:0] idx);
        logic [7:0] val;
        val = 8'h00;
        if (idx < 5'(CNTC_SEG_LEN)) begin
            val = list[idx];
        end
        return val;
    endfunction

    // ----------------------------------------------------------------
    // boot select pin
    // ----------------------------------------------------------------
    cntc_sync #(.RST_VAL(CNTC_BOOT_RST)) u_boot_sync (
        .clk(clk),
        .rst(rst),
        .pin_in(boot_select),
        .level_out(boot_level)
    );

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    assign busy = (state_reg != ST_IDLE); // R1 R2
    // store refused while protected or busy
    assign start_store = reg_wr && (reg_addr == CNTC_OFS_CTRL2) && reg_wdata[CNTC_BIT_STORE]
                         && wren_reg && !busy; // R6 R7 R11
    // reload only with boot select low
    assign start_load = reg_wr && (reg_addr == CNTC_OFS_CTRL1) && reg_wdata[CNTC_BIT_SOFT]
                        && !boot_level && !busy; // R5
    assign entry = seg_at(seg_reg, ptr_reg);
    // address bytes that follow a count entry
    assign entry_hi = seg_at(seg_reg, ptr_reg + 5'h01);
    assign entry_lo = seg_at(seg_reg, ptr_reg + 5'h02);

    // ----------------------------------------------------------------
    // transfer engine
    // ----------------------------------------------------------------
    // next state of the segment walker and byte mover
    always_comb begin
        state_next = state_reg;
        ptr_next = ptr_reg;
        cnt_next = cnt_reg;
        baddr_next = baddr_reg;
        naddr_next = naddr_reg;
        data_next = data_reg;
        sum_next = sum_reg;
        dir_next = dir_reg;
        err_next = err_reg;
        apply_eng = 1'b0;
        step = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (start_store || start_load) begin
                    dir_next = start_store;
                    ptr_next = 5'h00;
                    naddr_next = 12'h000;
                    sum_next = 8'h00;
                    state_next = ST_SEG;
                end
            end
            ST_SEG: begin
                if (entry == CNTC_OP_APPLY) begin
                    apply_eng = 1'b1; // R9
                    ptr_next = ptr_reg + 5'h01;
                end else if (entry != 8'h00 && !entry[7]
                             && ptr_reg <= 5'(CNTC_SEG_LEN - 3)) begin
                    cnt_next = entry[6:0]; // R9
                    baddr_next = {entry_hi[3:0], entry_lo};
                    ptr_next = ptr_reg + 5'h03;
                    state_next = ST_RD;
                end else begin
                    // end of data: check byte follows the payload
                    data_next = sum_reg;
                    state_next = ST_CHK;
                end
            end
            ST_RD: begin
                if (dir_reg) begin
                    data_next = buf_rdata;
                end
                state_next = ST_REQ;
            end
            ST_REQ: begin
                if (nvm_ack) begin
                    sum_next = sum_reg + (dir_reg ? data_reg : nvm_rdata);
                    naddr_next = naddr_reg + 12'h001;
                    if (dir_reg) begin
                        step = 1'b1;
                    end else begin
                        data_next = nvm_rdata;
                        state_next = ST_WR;
                    end
                end
            end
            ST_WR: begin
                step = 1'b1;
            end
            ST_CHK: begin
                if (nvm_ack) begin
                    err_next = dir_reg ? 1'b0 : (nvm_rdata != sum_reg); // R4 R11
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // advance within the current run
        if (step) begin
            baddr_next = baddr_reg + 12'h001;
            cnt_next = cnt_reg - 7'h01;
            state_next = (cnt_reg == 7'h01) ? ST_SEG : ST_RD;
        end
    end

    // engine registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            ptr_reg <= 5'h00;
            cnt_reg <= 7'h00;
            baddr_reg <= 12'h000;
            naddr_reg <= 12'h000;
            data_reg <= 8'h00;
            sum_reg <= 8'h00;
            dir_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
            cnt_reg <= cnt_next;
            baddr_reg <= baddr_next;
            naddr_reg <= naddr_next;
            data_reg <= data_next;
            sum_reg <= sum_next;
            dir_reg <= dir_next;
            err_reg <= err_next;
        end
    end

    // ----------------------------------------------------------------
    // control registers and read port
    // ----------------------------------------------------------------
    // register writes, self-clearing bits and readback
    always_comb begin
        seg_next = seg_reg;
        wren_next = wren_reg;
        stat_en_next = stat_en_reg;
        store_next = store_reg;
        soft_next = soft_reg;
        rdata_next = rdata_reg;
        apply_next = apply_eng;
        if (reg_wr) begin
            if (reg_addr == CNTC_OFS_CTRL1) begin
                wren_next = reg_wdata[CNTC_BIT_WREN]; // R6
            end else if (reg_addr == CNTC_OFS_STAT_PIN) begin
                stat_en_next = reg_wdata[CNTC_BIT_STAT_BUSY];
            end else if (reg_addr == CNTC_OFS_APPLY) begin
                apply_next = apply_eng || reg_wdata[CNTC_BIT_APPLY]; // R10
            end else if (reg_addr >= CNTC_OFS_SEG_FIRST && reg_addr <= CNTC_OFS_SEG_LAST
                         && !busy) begin
                seg_next[5'(reg_addr - CNTC_OFS_SEG_FIRST)] = reg_wdata;
            end
        end
        // bits clear at the end of their own transfer
        if (state_reg == ST_DONE) begin
            store_next = 1'b0; // R8
            soft_next = 1'b0; // R5
        end
        if (start_store) begin
            store_next = 1'b1; // R7
        end
        if (start_load) begin
            soft_next = 1'b1;
        end
        if (reg_rd) begin
            rdata_next = 8'h00;
            if (reg_addr == CNTC_OFS_BUSY) begin
                rdata_next[CNTC_BIT_BUSY] = busy; // R1
            end else if (reg_addr == CNTC_OFS_ERR) begin
                rdata_next[CNTC_BIT_ERR] = err_reg; // R4
            end else if (reg_addr == CNTC_OFS_CTRL1) begin
                rdata_next[CNTC_BIT_WREN] = wren_reg;
                rdata_next[CNTC_BIT_SOFT] = soft_reg;
            end else if (reg_addr == CNTC_OFS_CTRL2) begin
                rdata_next[CNTC_BIT_STORE] = store_reg;
            end else if (reg_addr == CNTC_OFS_STAT_PIN) begin
                rdata_next[CNTC_BIT_STAT_BUSY] = stat_en_reg;
            end else if (reg_addr >= CNTC_OFS_SEG_FIRST && reg_addr <= CNTC_OFS_SEG_LAST) begin
                rdata_next = seg_reg[5'(reg_addr - CNTC_OFS_SEG_FIRST)];
            end
        end
    end

    // control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < CNTC_SEG_LEN; i++) begin
                seg_reg[i] <= CNTC_SEG_RST;
            end
            wren_reg <= CNTC_CTRL_RST;
            stat_en_reg <= CNTC_CTRL_RST;
            store_reg <= CNTC_CTRL_RST;
            soft_reg <= CNTC_CTRL_RST;
            apply_reg <= 1'b0;
            soft_pulse_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            seg_reg <= seg_next;
            wren_reg <= wren_next;
            stat_en_reg <= stat_en_next;
            store_reg <= store_next;
            soft_reg <= soft_next;
            apply_reg <= apply_next;
            soft_pulse_reg <= start_load; // R5
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = rdata_reg;
    assign status_output_zero = stat_en_reg ? busy : status_other; // R3
    assign buf_addr = baddr_reg;
    assign buf_wdata = data_reg;
    assign buf_we = (state_reg == ST_WR);
    assign nvm_req = (state_reg == ST_REQ) || (state_reg == ST_CHK);
    assign nvm_we = nvm_req && dir_reg; // R6
    assign nvm_addr = naddr_reg;
    assign nvm_wdata = data_reg;
    assign apply_pulse = apply_reg;
    assign soft_reset = soft_pulse_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_store_starts_busy: assert property (@(posedge clk) disable iff (rst) // R7
        start_store |=> busy && dir_reg && store_reg)
        else $error("store request did not start a store");
    a_protect_store: assert property (@(posedge clk) disable iff (rst) // R11
        (reg_wr && reg_addr == CNTC_OFS_CTRL2 && !wren_reg && !busy) |=> !busy)
        else $error("store started while write protected");
    a_store_clears: assert property (@(posedge clk) disable iff (rst) // R8
        (state_reg == ST_DONE && store_reg) |=> !store_reg && !busy)
        else $error("store bit did not clear after store");
    a_load_reset: assert property (@(posedge clk) disable iff (rst) // R5
        start_load |=> soft_reset && busy && !dir_reg ##1 !soft_reset)
        else $error("reload did not pulse soft reset and start load");
    a_status_pin: assert property (@(posedge clk) disable iff (rst) // R3
        stat_en_reg |-> status_output_zero == (state_reg != ST_IDLE))
        else $error("status pin does not follow busy");
    a_busy_read: assert property (@(posedge clk) disable iff (rst) // R1
        (reg_rd && reg_addr == CNTC_OFS_BUSY) |=> reg_rdata == {7'h00, $past(busy)})
        else $error("busy readback wrong");
    a_load_error: assert property (@(posedge clk) disable iff (rst) // R4
        (state_reg == ST_CHK && nvm_ack && !dir_reg)
        |=> err_reg == ($past(nvm_rdata) != $past(sum_reg)))
        else $error("error flag does not match check byte");
    a_apply_once: assert property (@(posedge clk) disable iff (rst) // R10
        (reg_wr && reg_addr == CNTC_OFS_APPLY && reg_wdata[0]) |=> apply_pulse)
        else $error("apply write gave no pulse");
    a_protect_nvm: assert property (@(posedge clk) disable iff (rst) // R6
        nvm_we |-> dir_reg && store_reg)
        else $error("memory written outside a store");
endmodule

// file: test/cntc_nvm_model.sv
// behavioural model of the buffer register bank and the nonvolatile memory
`timescale 1ns/1ps
module cntc_nvm_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // behaviour controls from the bench
    input wire logic slow,
    input wire logic corrupt,
    // buffer register bank
    input wire logic [11:0] buf_addr,
    output logic [7:0] buf_rdata,
    input wire logic [7:0] buf_wdata,
    input wire logic buf_we,
    // nonvolatile memory
    input wire logic nvm_req,
    input wire logic nvm_we,
    input wire logic [11:0] nvm_addr,
    input wire logic [7:0] nvm_wdata,
    output logic [7:0] nvm_rdata,
    output logic nvm_ack
);
    logic [7:0] buf_mem [0:4095];
    logic [7:0] mem [0:63];
    logic [7:0] rd_q;
    logic [1:0] cnt;

    // buffer reads are combinational from the address
    assign buf_rdata = buf_mem[buf_addr];
    // read data only valid in the ack cycle, inverted otherwise
    assign nvm_rdata = nvm_ack ? rd_q : ~rd_q;

    // buffer bank write port, the bench also preloads this array directly
    always @(posedge clk) begin
        if (buf_we) begin
            buf_mem[buf_addr] <= buf_wdata;
        end
    end

    // memory answers after 1 or 4 cycles, optional bit flip on reads
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 2'h0;
            nvm_ack <= 1'b0;
            rd_q <= 8'h00;
        end else begin
            nvm_ack <= 1'b0;
            if (nvm_req && !nvm_ack) begin
                if (cnt == (slow ? 2'h3 : 2'h0)) begin
                    nvm_ack <= 1'b1;
                    cnt <= 2'h0;
                    if (nvm_we) begin
                        mem[nvm_addr[5:0]] <= nvm_wdata;
                    end else begin
                        rd_q <= mem[nvm_addr[5:0]] ^ {7'h00, corrupt};
                    end
                end else begin
                    cnt <= cnt + 2'h1;
                end
            end
        end
    end
endmodule

// file: test/config_nvm_transfer_control_tb.sv
// self-checking testbench for the configuration memory transfer control block
`timescale 1ns/1ps
module config_nvm_transfer_control_tb;
    import cntc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, boot_select = 1'b0;
    logic status_other = 1'b0, slow = 1'b0, corrupt = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic buf_we, nvm_req, nvm_we, nvm_ack, status_output_zero, apply_pulse, soft_reset;
    logic [11:0] buf_addr, nvm_addr;
    logic [7:0] reg_rdata, buf_rdata, buf_wdata, nvm_wdata, nvm_rdata, d;
    logic [7:0] seg [0:4] = '{8'h02, 8'h01, 8'h10, 8'h80, 8'hFF};
    int mismatches = 0, num_checks = 0, n_soft = 0, n_apply = 0, n_req = 0, s0, a0;

    // ------------------------------------------------------------
    // clock, instances and event counters
    // ------------------------------------------------------------
    always #2 clk = ~clk;

    cntc_top DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .boot_select(boot_select),
        .status_other(status_other), .status_output_zero(status_output_zero),
        .buf_addr(buf_addr), .buf_rdata(buf_rdata), .buf_wdata(buf_wdata), .buf_we(buf_we),
        .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
        .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack), .apply_pulse(apply_pulse),
        .soft_reset(soft_reset));

    cntc_nvm_model model (.clk(clk), .rst(rst), .slow(slow), .corrupt(corrupt),
        .buf_addr(buf_addr), .buf_rdata(buf_rdata), .buf_wdata(buf_wdata), .buf_we(buf_we),
        .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
        .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack));

    // count pulses seen on the effect outputs and cycles with the memory request high
    always @(posedge clk) begin
        if (soft_reset === 1'b1) n_soft++;
        if (apply_pulse === 1'b1) n_apply++;
        if (nvm_req === 1'b1) n_req++;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask

    // read data is registered at the taking edge
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        v = reg_rdata;
    endtask

    // poll the busy register under a bounded count
    task automatic wait_idle();
        int k;
        for (k = 0; k < 500; k++) begin
            rd(CNTC_OFS_BUSY, d);
            if (d === 8'h00) break;
        end
        if (k == 500) begin
            mismatches++;
            $display("ERROR at %0t: transfer never finished", $time);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run time
    initial begin
        #60000;
        mismatches++;
        $display("ERROR at %0t: watchdog expired", $time);
        close_out();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        // reset values and the unmapped address
        rd(CNTC_OFS_BUSY, d); check(d, 8'h00);
        rd(CNTC_OFS_ERR, d); check(d, 8'h00);
        rd(CNTC_OFS_CTRL1, d); check(d, 8'h00);
        rd(CNTC_OFS_CTRL2, d); check(d, 8'h00);
        rd(CNTC_OFS_SEG_FIRST, d); check(d, CNTC_SEG_RST);
        rd(12'h100, d); check(d, 8'h00);
        status_other = 1'b1;
        @(posedge clk);
        #1 check({7'h00, status_output_zero}, 8'h01);
        status_other = 1'b0;
        $display("test reset done");
        // store while protected is dropped
        wr(CNTC_OFS_CTRL2, 8'h01);
        repeat (10) @(posedge clk);
        check(8'(n_req), 8'h00);
        rd(CNTC_OFS_CTRL2, d); check(d, 8'h00);
        $display("test protected done");
        // store with slow memory and busy routed to the pin
        for (int i = 0; i < 5; i++) wr(CNTC_OFS_SEG_FIRST + 12'(i), seg[i]);
        model.buf_mem[12'h110] = 8'h5A;
        model.buf_mem[12'h111] = 8'hC3;
        wr(CNTC_OFS_STAT_PIN, 8'h10);
        wr(CNTC_OFS_CTRL1, 8'h01);
        slow = 1'b1;
        wr(CNTC_OFS_CTRL2, 8'h01);
        check({7'h00, status_output_zero}, 8'h01);
        rd(CNTC_OFS_CTRL2, d); check(d, 8'h01);
        rd(CNTC_OFS_BUSY, d); check(d, 8'h01);
        wait_idle();
        check(model.mem[0], 8'h5A);
        check(model.mem[1], 8'hC3);
        check(model.mem[2], 8'h1D);
        rd(CNTC_OFS_CTRL2, d); check(d, 8'h00);
        rd(CNTC_OFS_ERR, d); check(d, 8'h00);
        check({7'h00, status_output_zero}, 8'h00);
        $display("test store done");
        // reload from memory into a cleared buffer
        model.buf_mem[12'h110] = 8'h00;
        model.buf_mem[12'h111] = 8'h00;
        a0 = n_apply;
        wr(CNTC_OFS_CTRL1, 8'h03);
        check({7'h00, soft_reset}, 8'h01);
        rd(CNTC_OFS_BUSY, d); check(d, 8'h01);
        wait_idle();
        check(model.buf_mem[12'h110], 8'h5A);
        check(model.buf_mem[12'h111], 8'hC3);
        rd(CNTC_OFS_CTRL1, d); check(d, 8'h01);
        rd(CNTC_OFS_ERR, d); check(d, 8'h00);
        check(8'(n_apply - a0), 8'h01);
        $display("test reload done");
        // corrupted load sets the error, a later store clears it
        slow = 1'b0;
        corrupt = 1'b1;
        wr(CNTC_OFS_CTRL1, 8'h03);
        wait_idle();
        rd(CNTC_OFS_ERR, d); check(d, 8'h01);
        corrupt = 1'b0;
        wr(CNTC_OFS_CTRL2, 8'h01);
        wait_idle();
        rd(CNTC_OFS_ERR, d); check(d, 8'h00);
        $display("test error done");
        // reload refused while the boot select pin is high
        boot_select = 1'b1;
        repeat (6) @(posedge clk);
        s0 = n_soft;
        wr(CNTC_OFS_CTRL1, 8'h03);
        repeat (4) @(posedge clk);
        check(8'(n_soft - s0), 8'h00);
        rd(CNTC_OFS_BUSY, d); check(d, 8'h00);
        boot_select = 1'b0;
        $display("test boot pin done");
        // apply bit gives one pulse and reads back zero
        wr(CNTC_OFS_APPLY, 8'h01);
        check({7'h00, apply_pulse}, 8'h01);
        @(posedge clk);
        #1 check({7'h00, apply_pulse}, 8'h00);
        rd(CNTC_OFS_APPLY, d); check(d, 8'h00);
        $display("test apply done");
        close_out();
    end
endmodule
